// ---- core/core_pkg.sv ----
// shared constants for the flag-keeping processor core
package core_pkg;
    // ==========================================
    // processor flag register bit positions
    localparam int FLAG_C = 0; // carry
    localparam int FLAG_Z = 1; // zero result
    localparam int FLAG_N = 2; // negative result
    localparam int FLAG_V = 3; // two's complement overflow
    localparam int FLAG_S = 4; // sign, n xor v
    localparam int FLAG_H = 5; // half carry
    localparam int FLAG_T = 6; // bit copy store
    localparam int FLAG_I = 7; // global interrupt enable
    localparam logic [7:0] FLAGS_RESET = 8'h00; // interrupts off
    // ==========================================
    // instruction word fields
    localparam int OP_HI = 15;
    localparam int OP_LO = 11;
    localparam int RD_HI = 10;
    localparam int RD_LO = 6;
    localparam int RR_HI = 5;
    localparam int RR_LO = 1;
    localparam logic [15:0] INSN_NOP = 16'h0000; // bubble word
    // ==========================================
    // opcodes; two-word forms carry their operand in the next word
    localparam logic [4:0] OP_NOP = 5'h00;
    localparam logic [4:0] OP_ADD = 5'h01;
    localparam logic [4:0] OP_ADC = 5'h02;
    localparam logic [4:0] OP_SUB = 5'h03;
    localparam logic [4:0] OP_AND = 5'h04;
    localparam logic [4:0] OP_OR = 5'h05;
    localparam logic [4:0] OP_EOR = 5'h06;
    localparam logic [4:0] OP_MOV = 5'h07;
    localparam logic [4:0] OP_LDI = 5'h08; // two words
    localparam logic [4:0] OP_LDS = 5'h09; // two words
    localparam logic [4:0] OP_STS = 5'h0A; // two words
    localparam logic [4:0] OP_IN = 5'h0B;
    localparam logic [4:0] OP_OUT = 5'h0C;
    localparam logic [4:0] OP_LDP = 5'h0D; // load through pointer
    localparam logic [4:0] OP_STP = 5'h0E; // store through pointer
    localparam logic [4:0] OP_LPM = 5'h0F; // program table read via z
    localparam logic [4:0] OP_CALL = 5'h10; // two words
    localparam logic [4:0] OP_RET = 5'h11;
    localparam logic [4:0] OP_INTERRUPT_RETURN_OP = 5'h12; // interrupt_return_op
    localparam logic [4:0] OP_SEI = 5'h13; // global_irq_on_op
    localparam logic [4:0] OP_CLI = 5'h14; // global_irq_off_op
    localparam logic [4:0] OP_BST = 5'h15; // bit_store_to_flag_op
    localparam logic [4:0] OP_BLD = 5'h16; // bit_load_from_flag_op
    localparam logic [4:0] OP_JMP = 5'h17; // two words
    // ==========================================
    // data space map
    localparam logic [15:0] IO_BASE = 16'h0020; // first i/o data address
    localparam logic [15:0] IO_LAST = 16'h005F; // last i/o data address
    localparam logic [15:0] EXT_LAST = 16'h00FF; // last extended i/o address
    localparam logic [15:0] FLAG_DADDR = 16'h005F; // flag register, i/o 0x3F
    localparam logic [4:0] PTR_BASE = 5'h1A; // low byte of first pointer pair
    localparam logic [4:0] Z_LO = 5'h1E; // low byte of table pointer
    localparam logic [15:0] RESET_PC = 16'h0000; // reset vector
    localparam logic [15:0] VEC_STRIDE = 16'h0002; // words per vector
endpackage : core_pkg

// ---- core/cpu_core_status_flags.sv ----
// prefetching 8-bit core with register file, stack calls and flag register
// Summary of operation
// - fetch next word while current one executes
// - thirty-two 8-bit working registers, single cycle
// - alu reads two registers, writes back, one cycle
// - three register pairs act as 16-bit pointers
// - z pair also addresses program table reads
// - arithmetic updates the flag register
// - instructions are one or two 16-bit words
// - call and interrupt push return address
// - lower vector index wins interrupt priority
// - 64 i/o places at data 0x20-0x5F
// - extended i/o only through data loads/stores
// - flags are never saved on interrupt entry
// - bit 7 clear blocks every interrupt
// - interrupt clears bit 7, interrupt return sets it
// - bit 6 is the bit copy store
// - bit 5 holds half carry from nibble
// - bit 4 always n xor v
// - bit 3 flags signed overflow
// - bit 2 flags negative result
// - bit 1 flags zero result
// - bit 0 flags carry
module cpu_core_status_flags #(
    parameter int N_IRQ = 8, // interrupt request lines
    parameter logic [15:0] STACK_TOP = 16'h0FFF // initial stack pointer
) (
    input wire logic CLOCK, // core clock
    input wire logic RSTN, // asynchronous reset, active low
    output logic [15:0] PM_ADDR, // program word address
    input wire logic [15:0] PM_DATA, // program word at PM_ADDR
    output logic [15:0] DM_ADDR, // data space address
    output logic [7:0] DM_WDATA, // data space write byte
    output logic DM_WE, // data space write strobe
    output logic DM_RE, // data space read strobe
    input wire logic [7:0] DM_RDATA, // read byte for DM_ADDR
    input wire logic [N_IRQ-1:0] IRQ, // asynchronous request levels
    output logic [N_IRQ-1:0] IRQ_ACK, // one-cycle accept pulse
    output logic [7:0] FLAGS // processor_flag_register contents
);
    // ==========================================
    // parameter check
    if (N_IRQ < 1 || N_IRQ > 32) begin : g_bad_irq
        $error("N_IRQ must lie in 1..32");
    end

    typedef enum logic [2:0] {ST_RUN, ST_LOAD, ST_LPM, ST_PUSH_HI, ST_POP_HI, ST_POP_LO} state_t;

    // ==========================================
    // state
    state_t state; // sequencer step
    logic [15:0] ir; // instruction being executed
    logic ir_valid; // ir is a real fetched word, not a bubble
    logic [7:0] regs [32]; // working registers
    logic [7:0] processor_flags; // i t h s v n z c
    logic [15:0] sp; // stack pointer, grows down
    logic [15:0] ret_addr; // return address across push/pop steps
    logic [4:0] ld_rd; // destination of a pending load
    logic lpm_hi; // table read wants the high byte
    logic [N_IRQ-1:0] irq_m; // first synchroniser stage
    logic [N_IRQ-1:0] irq_s; // synchronised requests
    logic [N_IRQ-1:0] pick; // winning request, one-hot
    logic [15:0] vec; // vector of the winner

    assign FLAGS = processor_flags;

    // ==========================================
    // decode
    wire logic [4:0] op = ir[core_pkg::OP_HI:core_pkg::OP_LO];
    wire logic [4:0] rd_i = ir[core_pkg::RD_HI:core_pkg::RD_LO];
    wire logic [4:0] rr_i = ir[core_pkg::RR_HI:core_pkg::RR_LO];
    wire logic [7:0] a = regs[rd_i]; // first operand and store source
    wire logic [7:0] b = regs[rr_i]; // second operand
    wire logic run = (state == ST_RUN);
    wire logic take = run && ir_valid && processor_flags[core_pkg::FLAG_I] && (|irq_s);
    wire logic ex = run && !take; // ir executes this cycle
    wire logic is_alu = (op >= core_pkg::OP_ADD) && (op <= core_pkg::OP_EOR);
    wire logic two_word = (op == core_pkg::OP_LDI) || (op == core_pkg::OP_LDS)
        || (op == core_pkg::OP_STS) || (op == core_pkg::OP_CALL) || (op == core_pkg::OP_JMP);
    wire logic is_load = (op == core_pkg::OP_LDS) || (op == core_pkg::OP_IN)
        || (op == core_pkg::OP_LDP);
    wire logic is_store = (op == core_pkg::OP_STS) || (op == core_pkg::OP_OUT)
        || (op == core_pkg::OP_STP);

    // ==========================================
    // pointer pairs and data address
    // selector 3 has no pair and wraps to registers 0/1
    wire logic [4:0] ptr_lo = core_pkg::PTR_BASE + {2'h0, ir[1:0], 1'b0};
    wire logic [15:0] ptr = {regs[ptr_lo | 5'h01], regs[ptr_lo]};
    wire logic [15:0] z_ptr = {regs[core_pkg::Z_LO | 5'h01], regs[core_pkg::Z_LO]};
    // direct i/o numbers only reach 0x20-0x5F; extended space needs the word or pointer form
    wire logic [15:0] io_daddr = core_pkg::IO_BASE + {10'h000, ir[5:0]};
    wire logic [15:0] mem_addr = (op == core_pkg::OP_LDS || op == core_pkg::OP_STS) ? PM_DATA
        : (op == core_pkg::OP_IN || op == core_pkg::OP_OUT) ? io_daddr : ptr;
    wire logic flag_hit = (mem_addr == core_pkg::FLAG_DADDR); // served inside the core
    wire logic [15:0] ret_val = take ? PM_ADDR - 16'h0001 : PM_ADDR + 16'h0001;

    // ==========================================
    // alu: subtract is a + ~b + 1, carry out inverted gives borrow
    wire logic is_sub = (op == core_pkg::OP_SUB);
    wire logic cin = is_sub ^ ((op == core_pkg::OP_ADC) && processor_flags[core_pkg::FLAG_C]);
    wire logic [7:0] b_eff = is_sub ? ~b : b;
    wire logic [8:0] sum = {1'b0, a} + {1'b0, b_eff} + {8'h00, cin};
    wire logic [4:0] hsum = {1'b0, a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
    logic [7:0] alu_res; // result written back
    logic alu_arith; // arithmetic, as opposed to logic

    // logic ops keep h and c and clear v
    always_comb begin
        alu_res = sum[7:0];
        alu_arith = 1'b1;
        case (op)
            core_pkg::OP_AND: begin
                alu_res = a & b;
                alu_arith = 1'b0;
            end
            core_pkg::OP_OR: begin
                alu_res = a | b;
                alu_arith = 1'b0;
            end
            core_pkg::OP_EOR: begin
                alu_res = a ^ b;
                alu_arith = 1'b0;
            end
            default: ;
        endcase
    end

    wire logic f_c = alu_arith ? (sum[8] ^ is_sub) : processor_flags[core_pkg::FLAG_C];
    wire logic f_h = alu_arith ? (hsum[4] ^ is_sub) : processor_flags[core_pkg::FLAG_H];
    wire logic f_v = alu_arith && (a[7] == b_eff[7]) && (alu_res[7] != a[7]);
    wire logic f_n = alu_res[7];
    wire logic f_z = (alu_res == 8'h00);
    wire logic [5:0] alu_flags = {f_h, f_n ^ f_v, f_v, f_n, f_z, f_c};

    // ==========================================
    // bit copy helpers
    wire logic [7:0] bit_mask = 8'h01 << ir[2:0];
    wire logic bit_sel = a[ir[2:0]];
    wire logic [7:0] bld_val = processor_flags[core_pkg::FLAG_T] ? (a | bit_mask)
        : (a & ~bit_mask);

    // ==========================================
    // interrupt priority: lowest index, lowest vector, wins
    always_comb begin
        pick = '0;
        vec = core_pkg::RESET_PC;
        for (int i = N_IRQ - 1; i >= 0; i--) begin
            if (irq_s[i]) begin
                pick = '0;
                pick[i] = 1'b1;
                vec = 16'(core_pkg::VEC_STRIDE * 16'(i + 1));
            end
        end
    end

    // ==========================================
    // register file write port, one write per cycle
    logic wr_en; // write this cycle
    logic [4:0] wr_idx; // target register
    logic [7:0] wr_data; // byte written

    always_comb begin
        wr_en = 1'b0;
        wr_idx = rd_i;
        wr_data = alu_res;
        case (state)
            ST_LOAD: begin
                wr_en = 1'b1;
                wr_idx = ld_rd;
                wr_data = DM_RDATA;
            end
            ST_LPM: begin
                wr_en = 1'b1;
                wr_idx = ld_rd;
                wr_data = lpm_hi ? PM_DATA[15:8] : PM_DATA[7:0];
            end
            ST_RUN: begin
                if (ex && is_alu) wr_en = 1'b1;
                if (ex && op == core_pkg::OP_MOV) begin
                    wr_en = 1'b1;
                    wr_data = b;
                end
                if (ex && op == core_pkg::OP_LDI) begin
                    wr_en = 1'b1;
                    wr_data = PM_DATA[7:0];
                end
                if (ex && is_load && flag_hit) begin
                    wr_en = 1'b1;
                    wr_data = processor_flags;
                end
                if (ex && op == core_pkg::OP_BLD) begin
                    wr_en = 1'b1;
                    wr_data = bld_val;
                end
            end
            default: ;
        endcase
    end

    // data registers need no reset; software loads them
    always_ff @(posedge CLOCK) begin
        if (wr_en) regs[wr_idx] <= wr_data;
    end

    // ==========================================
    // request synchroniser and accept pulse
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            irq_m <= '0;
            irq_s <= '0;
            IRQ_ACK <= '0;
        end else begin
            irq_m <= IRQ;
            irq_s <= irq_m;
            IRQ_ACK <= take ? pick : '0;
        end
    end

    // ==========================================
    // sequencer, fetch and stack pointer
    // a two-word op consumes the prefetched word, leaving one bubble
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            state <= ST_RUN;
            PM_ADDR <= core_pkg::RESET_PC;
            ir <= core_pkg::INSN_NOP;
            ir_valid <= 1'b0;
            sp <= STACK_TOP;
            ret_addr <= 16'h0000;
            ld_rd <= 5'h00;
            lpm_hi <= 1'b0;
        end else begin
            case (state)
                ST_RUN: begin
                    if (take) begin
                        PM_ADDR <= vec;
                        ir <= core_pkg::INSN_NOP;
                        ir_valid <= 1'b0;
                        ret_addr <= ret_val;
                        sp <= sp - 16'h0001;
                        state <= ST_PUSH_HI;
                    end else begin
                        ir <= two_word ? core_pkg::INSN_NOP : PM_DATA;
                        ir_valid <= !two_word;
                        PM_ADDR <= PM_ADDR + 16'h0001;
                        ld_rd <= rd_i;
                        case (op)
                            core_pkg::OP_JMP: PM_ADDR <= PM_DATA;
                            core_pkg::OP_CALL: begin
                                PM_ADDR <= PM_DATA;
                                ret_addr <= ret_val;
                                sp <= sp - 16'h0001;
                                state <= ST_PUSH_HI;
                            end
                            core_pkg::OP_RET, core_pkg::OP_INTERRUPT_RETURN_OP: begin
                                PM_ADDR <= PM_ADDR;
                                ir <= core_pkg::INSN_NOP;
                                ir_valid <= 1'b0;
                                sp <= sp + 16'h0001;
                                state <= ST_POP_HI;
                            end
                            core_pkg::OP_LPM: begin
                                PM_ADDR <= {1'b0, z_ptr[15:1]};
                                ret_addr <= PM_ADDR;
                                ir <= core_pkg::INSN_NOP;
                                ir_valid <= 1'b0;
                                lpm_hi <= z_ptr[0];
                                state <= ST_LPM;
                            end
                            default: if (is_load && !flag_hit) state <= ST_LOAD;
                        endcase
                    end
                end
                // fetched word and address are held while the byte lands
                ST_LOAD: state <= ST_RUN;
                ST_LPM: begin
                    PM_ADDR <= ret_addr;
                    state <= ST_RUN;
                end
                ST_PUSH_HI: begin
                    sp <= sp - 16'h0001;
                    ir <= PM_DATA;
                    ir_valid <= 1'b1;
                    PM_ADDR <= PM_ADDR + 16'h0001;
                    state <= ST_RUN;
                end
                ST_POP_HI: begin
                    ret_addr[15:8] <= DM_RDATA;
                    sp <= sp + 16'h0001;
                    state <= ST_POP_LO;
                end
                ST_POP_LO: begin
                    PM_ADDR <= {ret_addr[15:8], DM_RDATA};
                    state <= ST_RUN;
                end
                default: state <= ST_RUN;
            endcase
        end
    end

    // ==========================================
    // data bus strobes; only the pc is pushed, never the flags
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            DM_ADDR <= 16'h0000;
            DM_WDATA <= 8'h00;
            DM_WE <= 1'b0;
            DM_RE <= 1'b0;
        end else begin
            DM_WE <= 1'b0;
            DM_RE <= 1'b0;
            if (take || (ex && op == core_pkg::OP_CALL)) begin
                DM_WE <= 1'b1;
                DM_ADDR <= sp;
                DM_WDATA <= ret_val[7:0];
            end else if (state == ST_PUSH_HI) begin
                DM_WE <= 1'b1;
                DM_ADDR <= sp;
                DM_WDATA <= ret_addr[15:8];
            end else if (state == ST_POP_HI
                || (ex && (op == core_pkg::OP_RET || op == core_pkg::OP_INTERRUPT_RETURN_OP))) begin
                DM_RE <= 1'b1;
                DM_ADDR <= sp + 16'h0001;
            end else if (ex && is_load && !flag_hit) begin
                DM_RE <= 1'b1;
                DM_ADDR <= mem_addr;
            end else if (ex && is_store && !flag_hit) begin
                DM_WE <= 1'b1;
                DM_ADDR <= mem_addr;
                DM_WDATA <= a;
            end
        end
    end

    // ==========================================
    // flag register; a software write recomputes s so it stays n xor v
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            processor_flags <= core_pkg::FLAGS_RESET;
        end else if (take) begin
            processor_flags[core_pkg::FLAG_I] <= 1'b0;
        end else if (ex) begin
            if (is_alu) processor_flags[5:0] <= alu_flags;
            if (op == core_pkg::OP_SEI || op == core_pkg::OP_INTERRUPT_RETURN_OP)
                processor_flags[core_pkg::FLAG_I] <= 1'b1;
            if (op == core_pkg::OP_CLI) processor_flags[core_pkg::FLAG_I] <= 1'b0;
            if (op == core_pkg::OP_BST) processor_flags[core_pkg::FLAG_T] <= bit_sel;
            if (is_store && flag_hit)
                processor_flags <= {a[7:5], a[2] ^ a[3], a[3:0]};
        end
    end

    // ==========================================
    // assertions
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RSTN);

    property p_prefetch;
        ex && is_alu |=> PM_ADDR == $past(PM_ADDR) + 16'h0001 && ir == $past(PM_DATA);
    endproperty
    a_prefetch: assert property (p_prefetch) else $error("prefetch did not advance");

    property p_alu_wb;
        ex && is_alu |=> regs[$past(rd_i)] == $past(alu_res);
    endproperty
    a_alu_wb: assert property (p_alu_wb) else $error("alu result not written");

    property p_zero;
        ex && is_alu |=> processor_flags[core_pkg::FLAG_Z] == $past(f_z);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");

    property p_sign;
        processor_flags[core_pkg::FLAG_S]
            == (processor_flags[core_pkg::FLAG_N] ^ processor_flags[core_pkg::FLAG_V]);
    endproperty
    a_sign: assert property (p_sign) else $error("sign is not n xor v");

    property p_gie_off;
        !processor_flags[core_pkg::FLAG_I] |=> IRQ_ACK == '0;
    endproperty
    a_gie_off: assert property (p_gie_off) else $error("interrupt taken while off");

    property p_take_clr;
        |IRQ_ACK |-> !processor_flags[core_pkg::FLAG_I] && PM_ADDR == $past(vec);
    endproperty
    a_take_clr: assert property (p_take_clr) else $error("entry left enable set");

    property p_prio;
        take |-> $onehot(pick) && (irq_s & (pick - 1'b1)) == '0 ##1 IRQ_ACK == $past(pick);
    endproperty
    a_prio: assert property (p_prio) else $error("wrong interrupt won");

    sequence s_push_lo;
        DM_WE && DM_ADDR == $past(sp);
    endsequence
    sequence s_push_hi;
        DM_WE && DM_ADDR == $past(sp, 2) - 16'h0001 && DM_WDATA == ret_addr[15:8];
    endsequence
    property p_call_push;
        ex && op == core_pkg::OP_CALL |=> s_push_lo ##1 s_push_hi;
    endproperty
    a_call_push: assert property (p_call_push) else $error("return address not pushed");

    property p_io_map;
        ex && op == core_pkg::OP_IN && !flag_hit |=> DM_RE && DM_ADDR >= core_pkg::IO_BASE
            && DM_ADDR <= core_pkg::IO_LAST;
    endproperty
    a_io_map: assert property (p_io_map) else $error("i/o read outside window");

    property p_bst;
        ex && op == core_pkg::OP_BST |=> processor_flags[core_pkg::FLAG_T] == $past(bit_sel);
    endproperty
    a_bst: assert property (p_bst) else $error("bit store missed");
endmodule : cpu_core_status_flags

// ---- test/mem_model.sv ----
// program and data memory model facing the core
module mem_model (
    input wire logic CLOCK, // core clock
    input wire logic [15:0] PM_ADDR, // word address
    output logic [15:0] PM_DATA, // word at address
    input wire logic [15:0] DM_ADDR, // byte address
    input wire logic [7:0] DM_WDATA, // write byte
    input wire logic DM_WE, // write strobe
    input wire logic DM_RE, // read strobe
    output logic [7:0] DM_RDATA // read byte
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // storage
    logic [15:0] rom [0:255]; // program words, loaded by the bench
    logic [7:0] ram [0:65535]; // data bytes
    logic [7:0] last = 8'h00; // last byte driven on a read
    assign PM_DATA = rom[PM_ADDR[7:0]]; // zero-wait fetch
    // an idle data line shows the inverse, so a stale byte never passes
    assign DM_RDATA = DM_RE ? ram[DM_ADDR] : ~last;
    // ==========================================
    // write port and read history
    always @(posedge CLOCK) begin
        if (DM_RE) last <= ram[DM_ADDR];
        if (DM_WE) ram[DM_ADDR] <= DM_WDATA;
    end
endmodule : mem_model

// ---- test/tb_cpu_core_status_flags.sv ----
// self-checking bench for the flag-keeping core
module tb_cpu_core_status_flags;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLOCK = 1'b0; // core clock
    logic RSTN = 1'b0; // reset, active low
    logic [7:0] IRQ = 8'h00; // request levels
    wire logic [15:0] pm_addr, pm_data, dm_addr;
    wire logic [7:0] dm_wdata, dm_rdata, irq_ack, flags;
    wire logic dm_we, dm_re;
    int n_fail = 0, n_compared = 0, seed = 62742;
    int a, b, r, c, h, v, n, z, k, acks;
    logic [4:0] ops [0:5] = '{core_pkg::OP_ADD, core_pkg::OP_ADC, core_pkg::OP_SUB,
        core_pkg::OP_AND, core_pkg::OP_OR, core_pkg::OP_EOR};
    always #2 CLOCK = ~CLOCK;
    cpu_core_status_flags #(.N_IRQ(8)) i_dut (.CLOCK(CLOCK), .RSTN(RSTN), .PM_ADDR(pm_addr),
        .PM_DATA(pm_data), .DM_ADDR(dm_addr), .DM_WDATA(dm_wdata), .DM_WE(dm_we),
        .DM_RE(dm_re), .DM_RDATA(dm_rdata), .IRQ(IRQ), .IRQ_ACK(irq_ack), .FLAGS(flags));
    mem_model i_mem (.CLOCK(CLOCK), .PM_ADDR(pm_addr), .PM_DATA(pm_data), .DM_ADDR(dm_addr),
        .DM_WDATA(dm_wdata), .DM_WE(dm_we), .DM_RE(dm_re), .DM_RDATA(dm_rdata));
    // ==========================================
    // helpers
    function automatic logic [15:0] ins(logic [4:0] op, logic [4:0] rd);
        return {op, rd, 6'h00};
    endfunction : ins
    task automatic check(logic [15:0] seen, logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : conclude
    // reset held five cycles, released off the sampling edge
    task automatic restart;
        @(negedge CLOCK);
        RSTN = 1'b0;
        repeat (5) @(negedge CLOCK);
        RSTN = 1'b1;
    endtask : restart
    // ==========================================
    // watchdog cuts a hang short
    initial begin
        #100000;
        n_fail++;
        conclude();
    end
    // ==========================================
    // main sequence; the programs never write program memory, so the
    // store-placement duty on software is trivially kept
    initial begin
        for (int i = 0; i < 256; i++) i_mem.rom[i] = core_pkg::INSN_NOP;
        for (int t = 0; t < 18; t++) begin
            k = t % 6;
            a = (t < 6) ? 128 : $random(seed) & 255; // boundary first, then random
            b = (t < 6) ? 128 : $random(seed) & 255;
            i_mem.rom[0] = ins(core_pkg::OP_LDI, 1);
            i_mem.rom[1] = 16'(a);
            i_mem.rom[2] = ins(core_pkg::OP_LDI, 2);
            i_mem.rom[3] = 16'(b);
            i_mem.rom[4] = {ops[k], 5'h01, 5'h02, 1'b0};
            i_mem.rom[5] = ins(core_pkg::OP_STS, 1);
            i_mem.rom[6] = 16'h0100;
            i_mem.rom[7] = ins(core_pkg::OP_JMP, 0);
            i_mem.rom[8] = 16'h0007;
            i_mem.ram[16'h0100] = 'x; // a stale result must never pass
            restart();
            repeat (20) @(negedge CLOCK);
            // reference model; carry starts clear after reset
            c = 0;
            h = 0;
            v = 0;
            if (k < 2) begin
                r = a + b;
                c = (r >> 8) & 1;
                h = ((a & 15) + (b & 15)) > 15;
                v = ((a ^ r) & (b ^ r) & 128) != 0;
            end else if (k == 2) begin
                r = a - b;
                c = b > a;
                h = (b & 15) > (a & 15);
                v = ((a ^ b) & (a ^ r) & 128) != 0;
            end else begin
                r = (k == 3) ? (a & b) : (k == 4) ? (a | b) : (a ^ b);
            end
            r = r & 255;
            n = r >> 7;
            z = r == 0;
            check({8'h00, i_mem.ram[16'h0100]}, 16'(r));
            check({8'h00, flags}, 16'(h*32 + (n^v)*16 + v*8 + n*4 + z*2 + c));
        end
        // requests while the global enable is clear are ignored
        i_mem.rom[0] = core_pkg::INSN_NOP;
        i_mem.rom[1] = ins(core_pkg::OP_JMP, 0);
        i_mem.rom[2] = 16'h0001;
        IRQ = 8'h0A;
        restart();
        acks = 0;
        repeat (30) @(negedge CLOCK) acks += (irq_ack !== 8'h00);
        check(16'(acks), 16'h0000);
        // enable, then two requests pending: lower index wins
        i_mem.rom[0] = ins(core_pkg::OP_SEI, 0);
        i_mem.rom[4] = ins(core_pkg::OP_JMP, 0);
        i_mem.rom[5] = 16'h0004;
        i_mem.ram[16'h0FFE] = 8'hFF;
        i_mem.ram[16'h0FFF] = 8'hFF;
        i_mem.ram[16'h0FFD] = 8'hFF; // a third pushed byte would land here
        restart();
        for (int w = 0; w < 40 && irq_ack === 8'h00; w++) @(negedge CLOCK);
        check({8'h00, irq_ack}, 16'h0002);
        check({15'h0000, flags[7]}, 16'h0000);
        IRQ = 8'h00;
        repeat (6) @(negedge CLOCK);
        // only the return address lands on the stack, the flags stay off it
        check({8'h00, i_mem.ram[16'h0FFE]}, 16'h0000);
        check({8'h00, i_mem.ram[16'h0FFF]}, 16'h0001);
        check({8'h00, i_mem.ram[16'h0FFD]}, 16'h00FF);
        // the vector loop alternates 4/5; this cycle sits on the vector word
        check(pm_addr, 16'h0004);
        // call a routine that copies a bit, reads i/o and writes the flags
        a = $random(seed) & 255;
        b = $random(seed) & 255;
        i_mem.rom[0] = ins(core_pkg::OP_LDI, 1);
        i_mem.rom[1] = 16'(a);
        i_mem.rom[2] = ins(core_pkg::OP_CALL, 0);
        i_mem.rom[3] = 16'h0010;
        i_mem.rom[4] = ins(core_pkg::OP_STS, 2);
        i_mem.rom[5] = 16'h0101;
        i_mem.rom[6] = ins(core_pkg::OP_STS, 3);
        i_mem.rom[7] = 16'h00A0; // extended i/o, only the word-form or pointer store reaches it
        i_mem.rom[8] = ins(core_pkg::OP_JMP, 0);
        i_mem.rom[9] = 16'h0008;
        i_mem.rom[16] = ins(core_pkg::OP_LDI, 2);
        i_mem.rom[17] = 16'h0000;
        i_mem.rom[18] = {core_pkg::OP_BST, 5'h01, 6'h07};
        i_mem.rom[19] = {core_pkg::OP_BLD, 5'h02, 6'h00};
        i_mem.rom[20] = {core_pkg::OP_IN, 5'h03, 6'h01};
        i_mem.rom[21] = {core_pkg::OP_OUT, 5'h01, 6'h3F};
        i_mem.rom[22] = ins(core_pkg::OP_RET, 0);
        restart();
        i_mem.ram[16'h0021] = 8'(b);
        i_mem.ram[16'h0101] = 'x;
        i_mem.ram[16'h00A0] = 'x;
        i_mem.ram[16'h0FFF] = 'x;
        repeat (30) @(negedge CLOCK);
        check({8'h00, i_mem.ram[16'h0FFF]}, 16'h0004);
        check({8'h00, i_mem.ram[16'h0101]}, 16'((a >> 7) & 1));
        check({8'h00, i_mem.ram[16'h00A0]}, 16'(b));
        check({8'h00, flags}, 16'((a & 239) | ((((a >> 3) ^ (a >> 2)) & 1) << 4)));
        conclude();
    end
endmodule : tb_cpu_core_status_flags
